// ===== asram_params.svh
`ifndef ASRAM_PARAMS_SVH
`define ASRAM_PARAMS_SVH

// ****************************************
// Geometry
// ****************************************
`define ASRAM_ADDR_W 17
`define ASRAM_DATA_W 8

// ****************************************
// Timing, slowest grade, in ns
// ****************************************
`define ASRAM_CLK_NS 10
`define ASRAM_ACCESS_DELAY_NS 15
`define ASRAM_LOCATION_SETUP_TO_END_NS 10
`define ASRAM_BYTE_SETUP_TO_END_NS 8
`define ASRAM_STROBE_TO_FLOAT_NS 7
`define ASRAM_SELECT_TO_DRIVE_NS 3
`define ASRAM_CEIL_CYC(ns) (((ns) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
// Read waits access delay plus two synchroniser stages on the returned byte.
`define ASRAM_READ_CYC (`ASRAM_CEIL_CYC(`ASRAM_ACCESS_DELAY_NS) + 2)
`define ASRAM_WRITE_CYC (`ASRAM_CEIL_CYC(`ASRAM_STROBE_TO_FLOAT_NS + `ASRAM_BYTE_SETUP_TO_END_NS))
// Turnaround after a read before the host may drive the lines again.
`define ASRAM_TURN_CYC 1
`define ASRAM_CNT_W 4
`endif

// ===== asram_pkg.sv
package asram_pkg;
  typedef enum logic [2:0] {
    ASRAM_IDLE,
    ASRAM_RD,
    ASRAM_TURN,
    ASRAM_WR_SETUP,
    ASRAM_WR,
    ASRAM_WR_END
  } asram_state_t;
endpackage

// ===== asram_timer_if.sv
`include "asram_params.svh"
interface asram_timer_if;
  logic load;
  logic [`ASRAM_CNT_W-1:0] count;
  logic done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// ===== asram_timer.sv
`include "asram_params.svh"
module asram_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  asram_timer_if.timer tmr
);
  logic [`ASRAM_CNT_W-1:0] left_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= '0;
    end else if (tmr.load) begin
      left_q <= tmr.count;
    end else if (left_q != '0) begin
      left_q <= left_q - `ASRAM_CNT_W'(1);
    end
  end

  // Done looks at the count alone, so an owner that loads on done closes no loop.
  assign tmr.done = (left_q == '0);
endmodule

// ===== asram_ctrl.sv
`include "asram_params.svh"
module asram_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`ASRAM_ADDR_W-1:0] req_addr,
  input wire logic [`ASRAM_DATA_W-1:0] req_wdata,
  // User read answer
  output logic rsp_valid,
  output logic [`ASRAM_DATA_W-1:0] rsp_rdata,
  // Memory pins
  output logic [`ASRAM_ADDR_W-1:0] location_lines,
  output logic select_n,
  output logic drive_enable_n,
  output logic write_strobe_n,
  input wire logic [`ASRAM_DATA_W-1:0] byte_lines_i,
  output logic [`ASRAM_DATA_W-1:0] byte_lines_o,
  output logic byte_lines_oe
);
  // ****************************************
  // State
  // ****************************************
  asram_pkg::asram_state_t state_q;
  logic [`ASRAM_DATA_W-1:0] sync1_q;
  logic [`ASRAM_DATA_W-1:0] sync2_q;
  logic rsp_valid_q;
  logic [`ASRAM_DATA_W-1:0] rsp_rdata_q;
  logic take;
  logic rd_last;
  // Next values of the pin registers.
  logic select_n_d;
  logic write_strobe_n_d;
  logic drive_enable_n_d;
  logic byte_lines_oe_d;

  asram_timer_if tif ();

  asram_timer u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tmr(tif)
  );

  // A timed phase ends in the cycle in which its own state sees the timer run out.
  function automatic logic phase_done(input asram_pkg::asram_state_t cur,
                                      input asram_pkg::asram_state_t phase,
                                      input logic done);
    return (cur == phase) && done;
  endfunction

  assign rd_last = phase_done(state_q, asram_pkg::ASRAM_RD, tif.done);
  assign req_ready = (state_q == asram_pkg::ASRAM_IDLE);
  assign take = req_ready && req_valid;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;

  // ****************************************
  // Sequencer
  // ****************************************
  // One timer serves every phase but ASRAM_IDLE and ASRAM_WR_END; each timed phase loads its own count on entry.
  always_comb begin
    tif.load = 1'b0;
    tif.count = '0;
    unique case (state_q)
      asram_pkg::ASRAM_IDLE: begin
        if (take) begin
          tif.load = 1'b1;
          tif.count = req_write ? `ASRAM_CNT_W'(1) : `ASRAM_CNT_W'(`ASRAM_READ_CYC);
        end
      end
      asram_pkg::ASRAM_RD: begin
        if (tif.done) begin
          tif.load = 1'b1;
          tif.count = `ASRAM_CNT_W'(`ASRAM_TURN_CYC);
        end
      end
      asram_pkg::ASRAM_WR_SETUP: begin
        if (tif.done) begin
          tif.load = 1'b1;
          tif.count = `ASRAM_CNT_W'(`ASRAM_WRITE_CYC);
        end
      end
      asram_pkg::ASRAM_TURN, asram_pkg::ASRAM_WR, asram_pkg::ASRAM_WR_END: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= asram_pkg::ASRAM_IDLE;
    end else begin
      unique case (state_q)
        asram_pkg::ASRAM_IDLE: begin
          if (take) begin
            state_q <= req_write ? asram_pkg::ASRAM_WR_SETUP : asram_pkg::ASRAM_RD;
          end
        end
        asram_pkg::ASRAM_RD: begin
          if (tif.done) begin
            state_q <= asram_pkg::ASRAM_TURN;
          end
        end
        asram_pkg::ASRAM_TURN: begin
          if (tif.done) begin
            state_q <= asram_pkg::ASRAM_IDLE;
          end
        end
        asram_pkg::ASRAM_WR_SETUP: begin
          if (tif.done) begin
            state_q <= asram_pkg::ASRAM_WR;
          end
        end
        asram_pkg::ASRAM_WR: begin
          if (tif.done) begin
            state_q <= asram_pkg::ASRAM_WR_END;
          end
        end
        asram_pkg::ASRAM_WR_END: begin
          state_q <= asram_pkg::ASRAM_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Address and data are held from request to idle, so they stay stable
  // across the whole write and beyond the edge that ends it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      location_lines <= '0;
      byte_lines_o <= '0;
    end else if (take) begin
      location_lines <= req_addr;
      byte_lines_o <= req_wdata;
    end
  end

  // Select stays low through the write end; the strobe alone ends it.
  // Data stays driven one cycle past the strobe, since hold costs nothing here.
  always_comb begin
    select_n_d = 1'b1;
    write_strobe_n_d = 1'b1;
    drive_enable_n_d = 1'b1;
    byte_lines_oe_d = 1'b0;
    unique case (state_q)
      asram_pkg::ASRAM_IDLE: begin
        if (take) begin
          select_n_d = 1'b0;
          drive_enable_n_d = req_write;
          byte_lines_oe_d = req_write;
        end
      end
      asram_pkg::ASRAM_RD: begin
        select_n_d = tif.done;
        drive_enable_n_d = tif.done;
      end
      asram_pkg::ASRAM_WR_SETUP: begin
        select_n_d = 1'b0;
        write_strobe_n_d = !tif.done;
        byte_lines_oe_d = 1'b1;
      end
      asram_pkg::ASRAM_WR: begin
        select_n_d = 1'b0;
        write_strobe_n_d = tif.done;
        byte_lines_oe_d = 1'b1;
      end
      asram_pkg::ASRAM_TURN, asram_pkg::ASRAM_WR_END: begin
        // Every control pin is released: the memory floats and the host keeps off.
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      drive_enable_n <= 1'b1;
      byte_lines_oe <= 1'b0;
    end else begin
      select_n <= select_n_d;
      write_strobe_n <= write_strobe_n_d;
      drive_enable_n <= drive_enable_n_d;
      byte_lines_oe <= byte_lines_oe_d;
    end
  end

  // ****************************************
  // Read capture
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= byte_lines_i;
      sync2_q <= sync1_q;
    end
  end

  // Capture at the last read cycle, before deselect lets prior data decay.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
    end else begin
      rsp_valid_q <= rd_last;
      if (rd_last) begin
        rsp_rdata_q <= sync2_q;
      end
    end
  end
endmodule

// ===== asram_monitor.sv
`include "asram_params.svh"
module asram_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  // Memory pins
  input wire logic [`ASRAM_ADDR_W-1:0] location_lines,
  input wire logic select_n,
  input wire logic drive_enable_n,
  input wire logic write_strobe_n,
  input wire logic [`ASRAM_DATA_W-1:0] byte_lines_o,
  input wire logic byte_lines_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic take_rd;
  logic take_wr;
  assign take_rd = req_valid && req_ready && !req_write;
  assign take_wr = req_valid && req_ready && req_write;
  AST_NO_CONTENTION: assert property (
    byte_lines_oe |-> select_n || drive_enable_n || !write_strobe_n) else $error("contention");
  AST_TURNAROUND: assert property (
    $rose(drive_enable_n) |-> !byte_lines_oe) else $error("no turnaround");
  AST_STROBE_SELECTED: assert property (
    !write_strobe_n |-> !select_n && byte_lines_oe) else $error("strobe unselected");
  AST_ADDR_STABLE: assert property (
    !select_n && $past(!select_n) |-> $stable(location_lines)) else $error("address moved");
  AST_DATA_STABLE: assert property (
    $past(!write_strobe_n) |-> $stable(byte_lines_o)) else $error("data moved");
  AST_WRITE_LEN: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n [*2]) else $error("strobe short");
  AST_SETUP: assert property (
    $fell(write_strobe_n) |-> $past(!select_n) && $past(byte_lines_oe) && $stable(location_lines))
    else $error("no setup");
  AST_READ_PINS: assert property (
    take_rd |=> !select_n && !drive_enable_n && write_strobe_n && !byte_lines_oe)
    else $error("read pins");
  AST_WRITE_START: assert property (
    take_wr |-> ##[1:3] !write_strobe_n) else $error("no write");
endmodule
bind asram_ctrl asram_monitor u_mon (.clk_sys, .rst_n, .req_valid, .req_ready, .req_write,
  .location_lines, .select_n, .drive_enable_n, .write_strobe_n, .byte_lines_o, .byte_lines_oe);

// ===== asram_mem_model.sv
`include "asram_params.svh"
module asram_mem_model #(
  parameter int ACC_NS = 15,
  parameter int KEEP_NS = 3
) (
  // Memory pins
  input wire logic [`ASRAM_ADDR_W-1:0] location_lines,
  input wire logic select_n,
  input wire logic drive_enable_n,
  input wire logic write_strobe_n,
  // Host side of the byte lines, resolved here
  input wire logic [`ASRAM_DATA_W-1:0] byte_lines_o,
  input wire logic byte_lines_oe,
  output logic [`ASRAM_DATA_W-1:0] byte_lines_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [`ASRAM_DATA_W-1:0] mem [0:(1<<`ASRAM_ADDR_W)-1];
  logic [`ASRAM_ADDR_W-1:0] wa;
  logic [`ASRAM_ADDR_W-1:0] addr_d;
  logic [`ASRAM_ADDR_W-1:0] addr_k;
  logic [`ASRAM_DATA_W-1:0] wd;
  logic rd;
  logic rd_d;
  logic wr;
  assign wr = !select_n && !write_strobe_n;
  assign rd = !select_n && !drive_enable_n && write_strobe_n;
  // Inertial delays drop a read that is released or moved before the access delay ends.
  assign #(ACC_NS) rd_d = rd;
  assign #(ACC_NS) addr_d = location_lines;
  // The prior byte stays for the keep time after a move, then the bus is bad until access ends.
  assign #(KEEP_NS) addr_k = location_lines;
  always @* if (wr) begin
    wa = location_lines;
    wd = byte_lines_oe ? byte_lines_o : 'x;
  end
  always @(negedge wr) mem[wa] = wd;
  // A floating bus shows the inverted byte, so an early sample never matches by luck.
  always_comb
    if (byte_lines_oe) byte_lines_i = byte_lines_o;
    else if (rd && rd_d && addr_d == addr_k) byte_lines_i = mem[addr_k];
    else byte_lines_i = ~mem[location_lines];
endmodule

// ===== async_sram_128k_x8_tb_top.sv
`include "asram_params.svh"
module async_sram_128k_x8_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic [`ASRAM_ADDR_W-1:0] req_addr = 17'h0, location_lines;
  logic [`ASRAM_DATA_W-1:0] req_wdata = 8'h0, rsp_rdata, byte_lines_i, byte_lines_o;
  logic req_ready, rsp_valid, select_n, drive_enable_n, write_strobe_n, byte_lines_oe;
  logic [16:0] adr [4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555};
  int mismatches = 0, n_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  asram_ctrl u_dut (.clk_sys, .rst_n, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .rsp_valid, .rsp_rdata, .location_lines, .select_n, .drive_enable_n,
    .write_strobe_n, .byte_lines_i, .byte_lines_o, .byte_lines_oe);
  asram_mem_model u_mem (.location_lines, .select_n, .drive_enable_n, .write_strobe_n,
    .byte_lines_o, .byte_lines_oe, .byte_lines_i);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n = 0;
    @(negedge clk_sys);
    req_valid = 1'h1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'h1 && n++ < 20) @(negedge clk_sys);
    check({7'h0, req_ready}, 8'h01);
    @(negedge clk_sys);
    req_valid = 1'h0;
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] e);
    int n = 0;
    req(1'h0, a, 8'h0);
    while (rsp_valid !== 1'h1 && n++ < 20) @(negedge clk_sys);
    check({7'h0, rsp_valid}, 8'h01);
    check(rsp_rdata, e);
  endtask
  task automatic t_idle();
    check({select_n, drive_enable_n, write_strobe_n, byte_lines_oe, req_ready, 3'h0}, 8'he8);
  endtask
  task automatic t_fill();
    foreach (adr[i]) req(1'h1, adr[i], 8'h3c ^ adr[i][7:0]);
    foreach (adr[i]) rd(adr[i], 8'h3c ^ adr[i][7:0]);
    req(1'h1, 17'h0, 8'ha5);
    rd(17'h0, 8'ha5);
    rd(17'h1ffff, 8'hc3);
    $display("test fill done");
  endtask
  task automatic t_mid_reset();
    req(1'h1, 17'h00100, 8'h77);
    @(negedge clk_sys);
    rst_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    t_idle();
    rst_n = 1'h1;
    rd(17'h0aaaa, 8'h96);
    $display("test mid reset done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc == 2000) begin
    mismatches++;
    test_done();
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'h1;
    t_idle();
    t_fill();
    t_mid_reset();
    test_done();
  end
endmodule
